// ### src/cma_defines.vh
/*
 Constants of the core memory addressing block: widths, reset values,
 data map split points, opcode fields and bank layout.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CMA_DEFINES_VH
`define CMA_DEFINES_VH

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define CMA_PCW_W       20
`define CMA_DA_W        12
`define CMA_BANK_W      4
`define CMA_PCW_RST     20'h00000
`define CMA_PCW_STEP    20'h00001
`define CMA_BP_RST      4'h0
`define CMA_DA_RST      12'h000

// ------------------------------------------------------------
// data map
// ------------------------------------------------------------
`define CMA_BP_ADDR     12'hFE0
`define CMA_ACC_SPLIT   8'h60
`define CMA_ACC_LO_BANK 4'h0
`define CMA_ACC_HI_BANK 4'hF
`define CMA_IMPL_BANKS  16'h8007
`define CMA_USB_BANK    4'h2

// ------------------------------------------------------------
// opcode fields
// ------------------------------------------------------------
`define CMA_ABIT        8
`define CMA_NIB_SECOND  4'hF
`define CMA_NIB_FMOVE   4'hC
`define CMA_NIB_FOP_LO  4'h2
`define CMA_NIB_FOP_HI  4'hB
`define CMA_OP_GOTO     8'hEF
`define CMA_OP_PLOAD    8'hEE
`define CMA_OP_CALL     7'h76
`define CMA_OP_BLOAD    8'h01
`define CMA_OP_BRA      5'h1A

`endif

// ### src/cma_amap.v
/*
 Data address former: full address, banked, or shortcut bank map,
 plus an implemented-bank flag for the resolved address.
 Assumes the caller registers whatever it keeps.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cma_defines.vh"

module cma_amap #(
   parameter [15:0] IMPL_BANKS = `CMA_IMPL_BANKS
) (
   input  wire        use_full_i,
   input  wire [11:0] full_addr_i,
   input  wire        abit_i,
   input  wire [7:0]  operand_i,
   input  wire [3:0]  bank_i,
   output reg  [11:0] addr_o,
   output reg         impl_o
);

   always @* begin
      if (use_full_i) begin
         addr_o = full_addr_i; // RULE_17
      end else if (abit_i) begin
         addr_o = {bank_i, operand_i}; // RULE_13
      end else if (operand_i < `CMA_ACC_SPLIT) begin
         addr_o = {`CMA_ACC_LO_BANK, operand_i}; // RULE_20
      end else begin
         addr_o = {`CMA_ACC_HI_BANK, operand_i}; // RULE_11
      end
      // upper four bits pick one of sixteen 256-byte banks
      impl_o = IMPL_BANKS[addr_o[11:8]]; // RULE_09
   end

endmodule
`default_nettype wire

// ### src/cma_dram.v
/*
 Dual-port data RAM with registered reads. Port A serves the core,
 port B the usb serial engine. Port A write wins on a same-cell clash.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module cma_dram #(
   parameter AW = 12,
   parameter DW = 8
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire [AW-1:0] a_addr_i,
   input  wire          a_re_i,
   input  wire          a_ok_i,
   input  wire          a_we_i,
   input  wire [DW-1:0] a_wdata_i,
   output reg  [DW-1:0] a_rdata_o,
   input  wire [AW-1:0] b_addr_i,
   input  wire          b_we_i,
   input  wire [DW-1:0] b_wdata_i,
   output reg  [DW-1:0] b_rdata_o
);

   // contents are not cleared by reset
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk_i) begin
      if (b_we_i) begin
         mem[b_addr_i] <= b_wdata_i;
      end
      if (a_we_i) begin
         mem[a_addr_i] <= a_wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         a_rdata_o <= {DW{1'b0}};
         b_rdata_o <= {DW{1'b0}};
      end else begin
         if (a_re_i) begin
            // unimplemented cells read as zero
            a_rdata_o <= a_ok_i ? mem[a_addr_i] : {DW{1'b0}}; // RULE_10
         end
         b_rdata_o <= mem[b_addr_i];
      end
   end

endmodule
`default_nettype wire

// ### src/cma_core_addr.v
/*
 Addressing logic of an 8-bit core: program counter, two-word
 instruction decode, branch targets, bank pointer and data address
 forming, with the data RAM behind it.
 Assumes the core's fetch/execute sequencing on the same clock drives
 step_i with the fetched word; usb_en_i comes from a register on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cma_defines.vh"

// Summary of operation
// RULE_01: program memory byte addressed, one or two words
// RULE_02: low byte at even address, high at odd
// RULE_03: pc advances two bytes, bit zero reads 0
// RULE_04: call/jump target word address loads pc 20:1
// RULE_05: branch offset counts words, bytes doubled
// RULE_06: four two-word instructions, second word 1111
// RULE_07: lone 1111 word is a no-operation
// RULE_08: data memory 12-bit address, 4096 bytes
// RULE_09: sixteen banks of 256 bytes, upper bits
// RULE_10: unimplemented locations read as zero
// RULE_11: shortcut bank reaches special and low storage
// RULE_12: usb banks shared with engine when enabled
// RULE_13: banked address is bank pointer plus operand
// RULE_14: bank pointer upper nibble reads zero, unwritable
// RULE_15: bank literal load writes the bank pointer
// RULE_16: unimplemented writes dropped, flags still update
// RULE_17: full address move ignores bank pointer
// RULE_18: other data ops use bank or shortcut
// RULE_19: access bit picks bank pointer or shortcut
// RULE_20: shortcut maps 00-5F bank 0, 60-FF bank 15
// RULE_21: fetch second word before finishing, then advance
module cma_core_addr #(
   parameter [15:0] IMPL_BANKS = `CMA_IMPL_BANKS,
   parameter [3:0]  USB_BANK   = `CMA_USB_BANK
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        step_i,
   input  wire        skip_i,
   input  wire [7:0]  prog_lo_i,
   input  wire [7:0]  prog_hi_i,
   input  wire        dwr_i,
   input  wire [7:0]  dwdata_i,
   input  wire        usb_en_i,
   input  wire [7:0]  eng_addr_i,
   input  wire        eng_we_i,
   input  wire [7:0]  eng_wdata_i,
   output wire [20:0] pc_o,
   output reg         busy_o,
   output reg         nop_o,
   output reg         call_o,
   output reg  [20:0] ret_addr_o,
   output reg         fsr_load_o,
   output reg  [1:0]  fsr_sel_o,
   output reg  [11:0] fsr_value_o,
   output wire [3:0]  bank_pointer_o,
   output reg  [11:0] daddr_o,
   output reg  [7:0]  drdata_o,
   output reg         flag_update_o,
   output wire [7:0]  eng_rdata_o
);

   // ------------------------------------------------------------
   // states and instruction kinds
   // ------------------------------------------------------------
   localparam [1:0] ST_FIRST  = 2'b00;
   localparam [1:0] ST_SECOND = 2'b01;
   localparam [1:0] ST_MOVWR  = 2'b10;

   localparam [3:0] K_OTHER  = 4'h0;
   localparam [3:0] K_SECOND = 4'h1;
   localparam [3:0] K_GOTO   = 4'h2;
   localparam [3:0] K_CALL   = 4'h3;
   localparam [3:0] K_PLOAD  = 4'h4;
   localparam [3:0] K_FMOVE  = 4'h5;
   localparam [3:0] K_BLOAD  = 4'h6;
   localparam [3:0] K_BRA    = 4'h7;
   localparam [3:0] K_FOP    = 4'h8;

   function [3:0] kind_of;
      input [15:0] w;
      begin
         if (w[15:12] == `CMA_NIB_SECOND)
            kind_of = K_SECOND;
         else if (w[15:8] == `CMA_OP_GOTO)
            kind_of = K_GOTO;
         else if (w[15:9] == `CMA_OP_CALL)
            kind_of = K_CALL;
         else if (w[15:8] == `CMA_OP_PLOAD)
            kind_of = K_PLOAD;
         else if (w[15:12] == `CMA_NIB_FMOVE)
            kind_of = K_FMOVE;
         else if (w[15:8] == `CMA_OP_BLOAD)
            kind_of = K_BLOAD;
         else if (w[15:11] == `CMA_OP_BRA)
            kind_of = K_BRA;
         else if (w[15:12] >= `CMA_NIB_FOP_LO &&
                  w[15:12] <= `CMA_NIB_FOP_HI)
            kind_of = K_FOP;
         else
            kind_of = K_OTHER;
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [19:0] pc_w;
   reg  [3:0]  bank_pointer;
   reg  [15:0] first;
   reg  [11:0] dst_addr;
   reg         rd_pend;
   reg         rd_bp;
   reg         acc_impl;
   reg         acc_bp;

   wire [15:0] word = {prog_hi_i, prog_lo_i}; // RULE_02
   wire [3:0]  wkind = kind_of(word);
   wire [3:0]  fkind = kind_of(first);
   // a core write holds off the step for that cycle
   wire        take = step_i & ~dwr_i & (state != ST_MOVWR);

   assign pc_o = {pc_w, 1'b0}; // RULE_03
   assign bank_pointer_o = bank_pointer;

   // ------------------------------------------------------------
   // data address forming and RAM port control
   // ------------------------------------------------------------
   reg         map_full;
   reg  [11:0] map_full_addr;
   wire [11:0] map_addr;
   wire        map_impl;
   wire        is_bp = (map_addr == `CMA_BP_ADDR);
   wire [7:0]  ram_rdata;
   wire [7:0]  mov_data = rd_bp ? {4'h0, bank_pointer} : ram_rdata;
   reg         ram_re;
   reg         ram_we;
   reg  [11:0] ram_addr;
   reg  [7:0]  ram_wdata;
   reg         mov_rd;

   always @* begin
      map_full      = 1'b0;
      map_full_addr = `CMA_DA_RST;
      if (state == ST_SECOND) begin
         map_full      = 1'b1; // RULE_17
         map_full_addr = first[11:0];
      end else if (state == ST_MOVWR) begin
         map_full      = 1'b1;
         map_full_addr = dst_addr;
      end
   end

   cma_amap #(
      .IMPL_BANKS (IMPL_BANKS)
   ) u_amap (
      .use_full_i  (map_full),
      .full_addr_i (map_full_addr),
      .abit_i      (word[`CMA_ABIT]), // RULE_19
      .operand_i   (word[7:0]), // RULE_18
      .bank_i      (bank_pointer),
      .addr_o      (map_addr),
      .impl_o      (map_impl)
   );

   always @* begin
      mov_rd = take & (state == ST_SECOND) & (fkind == K_FMOVE) &
               (wkind == K_SECOND);
      ram_re = (take & (state == ST_FIRST) & ~skip_i &
                (wkind == K_FOP)) | mov_rd;
      ram_we    = 1'b0;
      ram_addr  = map_addr;
      ram_wdata = dwdata_i;
      if (state == ST_MOVWR) begin
         // writes into missing banks just vanish
         ram_we    = map_impl & ~is_bp; // RULE_16
         ram_wdata = mov_data;
      end else if (dwr_i) begin
         ram_we   = acc_impl & ~acc_bp; // RULE_16
         ram_addr = daddr_o;
      end
   end

   cma_dram #(
      .AW (`CMA_DA_W), // RULE_08
      .DW (8)
   ) u_dram (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .a_addr_i  (ram_addr),
      .a_re_i    (ram_re),
      .a_ok_i    (map_impl), // RULE_10
      .a_we_i    (ram_we),
      .a_wdata_i (ram_wdata),
      .a_rdata_o (ram_rdata),
      .b_addr_i  ({USB_BANK, eng_addr_i}),
      .b_we_i    (eng_we_i & usb_en_i), // RULE_12
      .b_wdata_i (eng_wdata_i),
      .b_rdata_o (eng_rdata_o)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_FIRST: begin
            if (take & ~skip_i &
                (wkind == K_GOTO || wkind == K_CALL ||
                 wkind == K_PLOAD || wkind == K_FMOVE))
               next_state = ST_SECOND; // RULE_06
         end
         ST_SECOND: begin
            if (mov_rd)
               next_state = ST_MOVWR;
            else if (take)
               next_state = ST_FIRST;
         end
         ST_MOVWR: begin
            next_state = ST_FIRST;
         end
         default: begin
            next_state = ST_FIRST;
         end
      endcase
   end

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         state         <= ST_FIRST;
         busy_o        <= 1'b0;
         pc_w          <= `CMA_PCW_RST;
         bank_pointer  <= `CMA_BP_RST;
         first         <= 16'h0000;
         dst_addr      <= `CMA_DA_RST;
         rd_pend       <= 1'b0;
         rd_bp         <= 1'b0;
         acc_impl      <= 1'b0;
         acc_bp        <= 1'b0;
         nop_o         <= 1'b0;
         call_o        <= 1'b0;
         ret_addr_o    <= 21'h00000;
         fsr_load_o    <= 1'b0;
         fsr_sel_o     <= 2'h0;
         fsr_value_o   <= 12'h000;
         daddr_o       <= `CMA_DA_RST;
         drdata_o      <= 8'h00;
         flag_update_o <= 1'b0;
      end else begin
         state         <= next_state;
         busy_o        <= (next_state == ST_MOVWR);
         nop_o         <= 1'b0;
         call_o        <= 1'b0;
         fsr_load_o    <= 1'b0;
         flag_update_o <= 1'b0;
         rd_pend <= ram_re & ~mov_rd;
         rd_bp   <= ram_re & is_bp;
         if (rd_pend) begin
            // flags follow even a read of a missing bank
            drdata_o      <= mov_data;
            flag_update_o <= 1'b1; // RULE_16
         end
         if (dwr_i & acc_bp & (state != ST_MOVWR))
            bank_pointer <= dwdata_i[3:0]; // RULE_14
         case (state)
            ST_FIRST: begin
               if (take) begin
                  if (skip_i || wkind == K_SECOND) begin
                     pc_w  <= pc_w + `CMA_PCW_STEP; // RULE_07
                     nop_o <= 1'b1;
                  end else if (wkind == K_BRA) begin
                     pc_w <= pc_w + `CMA_PCW_STEP +
                             {{9{word[10]}}, word[10:0]}; // RULE_05
                  end else begin
                     pc_w <= pc_w + `CMA_PCW_STEP; // RULE_01
                     if (wkind == K_BLOAD)
                        bank_pointer <= word[3:0]; // RULE_15
                     if (next_state == ST_SECOND)
                        first <= word; // RULE_21
                     if (wkind == K_FOP) begin
                        daddr_o  <= map_addr;
                        acc_impl <= map_impl;
                        acc_bp   <= is_bp;
                     end
                  end
               end
            end
            ST_SECOND: begin
               if (take) begin
                  if (wkind == K_SECOND &&
                      (fkind == K_GOTO || fkind == K_CALL)) begin
                     pc_w <= {word[11:0], first[7:0]}; // RULE_04
                     if (fkind == K_CALL) begin
                        call_o     <= 1'b1;
                        ret_addr_o <= {pc_w + `CMA_PCW_STEP, 1'b0};
                     end
                  end else begin
                     pc_w <= pc_w + `CMA_PCW_STEP; // RULE_21
                     if (wkind == K_SECOND && fkind == K_PLOAD) begin
                        fsr_load_o  <= 1'b1;
                        fsr_sel_o   <= first[5:4];
                        fsr_value_o <= {first[3:0], word[7:0]};
                     end
                     if (mov_rd)
                        dst_addr <= word[11:0]; // RULE_06
                  end
               end
            end
            ST_MOVWR: begin
               if (is_bp)
                  bank_pointer <= mov_data[3:0]; // RULE_14
            end
            default: begin
               pc_w <= pc_w;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### bench/cma_fetch_model.sv
/*
 Fetch side of the core: byte-wide program store read at pc_i.
 Assumes the bench loads words before reset is released.
*/
`timescale 1ns/1ns
`default_nettype none

module cma_fetch_model (
   input  wire logic [20:0] pc_i,
   output wire logic [7:0]  prog_lo_o,
   output wire logic [7:0]  prog_hi_o
);
   logic [7:0] mem [128];

   // one word is two bytes, low byte at the even address
   task automatic put(input logic [7:0] a, input logic [15:0] w);
      mem[a[6:0]] = w[7:0];
      mem[a[6:0] + 7'd1] = w[15:8];
   endtask

   // out of range fetches give a lone second word, executed as no-op
   assign prog_lo_o = (pc_i[20:7] == 14'h0) ?
                      mem[{pc_i[6:1], 1'b0}] : 8'hFF;
   assign prog_hi_o = (pc_i[20:7] == 14'h0) ?
                      mem[{pc_i[6:1], 1'b1}] : 8'hFF;
endmodule

`default_nettype wire

// ### bench/cma_core_addr_monitor.sv
/*
 Checker for the core addressing block: pc steps, two-word decode,
 data address forming. Assumes a bind to cma_core_addr.
*/
`timescale 1ns/1ns
`default_nettype none

module cma_core_addr_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        step_i,
   input wire logic        skip_i,
   input wire logic [7:0]  prog_lo_i,
   input wire logic [7:0]  prog_hi_i,
   input wire logic        dwr_i,
   input wire logic [20:0] pc_o,
   input wire logic        busy_o,
   input wire logic        nop_o,
   input wire logic [3:0]  bank_pointer_o,
   input wire logic [11:0] daddr_o,
   input wire logic        flag_update_o
);
   // ---------------------------------
   // decode shadow
   // ---------------------------------
   logic [15:0] w;
   logic [15:0] fw;
   logic        tk;
   logic        two;
   logic        dop;
   logic        sec;
   logic        f1;
   assign w = {prog_hi_i, prog_lo_i};
   assign tk = step_i && !dwr_i && !busy_o;
   assign two = w[15:8] == 8'hEF || w[15:8] == 8'hEE || w[15:9] == 7'h76
                || w[15:12] == 4'hC;
   assign dop = w[15:12] >= 4'h2 && w[15:12] <= 4'hB;
   assign f1 = tk && !sec && !skip_i;

   // a skipped first word leaves its second word to run alone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec <= 1'b0;
         fw <= 16'h0000;
      end else if (tk) begin
         sec <= !sec && two && !skip_i;
         fw <= w;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ---------------------------------
   // assertions
   // ---------------------------------
   pc_lsb_zero_a: assert property (pc_o[0] == 1'b0)
      else $error("pc bit zero set");
   pc_step_two_a: assert property (
      tk && !sec && (two || dop || w[15:12] == 4'hF)
      |=> pc_o == $past(pc_o) + 21'd2)
      else $error("pc did not step by two");
   goto_load_a: assert property (
      tk && sec && fw[15:8] == 8'hEF && w[15:12] == 4'hF
      |=> pc_o == {$past(w[11:0]), $past(fw[7:0]), 1'b0})
      else $error("jump target wrong");
   branch_words_a: assert property (
      f1 && w[15:11] == 5'h1A
      |=> pc_o == $past(pc_o) + 21'd2 +
          {{9{$past(w[10])}}, $past(w[10:0]), 1'b0})
      else $error("branch target wrong");
   lone_word_nop_a: assert property (
      tk && !sec && (w[15:12] == 4'hF || skip_i) |=> nop_o)
      else $error("lone word not a no-op");
   bank_load_a: assert property (
      f1 && w[15:8] == 8'h01 |=> bank_pointer_o == $past(w[3:0]))
      else $error("bank literal not loaded");
   banked_addr_a: assert property (
      f1 && dop && w[8]
      |=> daddr_o == {$past(bank_pointer_o), $past(w[7:0])})
      else $error("banked address wrong");
   shortcut_addr_a: assert property (
      f1 && dop && !w[8]
      |=> daddr_o == {($past(w[7:0]) < 8'h60) ? 4'h0 : 4'hF,
                      $past(w[7:0])})
      else $error("shortcut address wrong");
   read_flag_a: assert property (
      f1 && dop |-> ##2 flag_update_o)
      else $error("status update missing");

   cover property (tk && sec && fw[15:12] == 4'hC);
   cover property (busy_o);
   cover property (f1 && dop && w[8]);
endmodule

`default_nettype wire

// ### bench/test_core_memory_addressing.sv
/*
 Bench for cma_core_addr: a program runs word by word from the fetch
 model while data reads, writes and engine accesses are checked.
 Assumes the 10 MHz clock and the default parameters.
*/
`timescale 1ns/1ns
`default_nettype none

module test_core_memory_addressing;
   logic        clk_i = 1'b0;
   logic        rst_i;
   logic        step_i;
   logic        skip_i;
   logic        dwr_i;
   logic        usb_en_i;
   logic        eng_we_i;
   logic [7:0]  dwdata_i;
   logic [7:0]  eng_addr_i;
   logic [7:0]  eng_wdata_i;
   wire  [7:0]  prog_lo_i;
   wire  [7:0]  prog_hi_i;
   wire  [20:0] pc_o;
   wire  [20:0] ret_addr_o;
   wire         busy_o;
   wire         nop_o;
   wire         call_o;
   wire         fsr_load_o;
   wire  [1:0]  fsr_sel_o;
   wire  [11:0] fsr_value_o;
   wire  [3:0]  bank_pointer_o;
   wire  [11:0] daddr_o;
   wire  [7:0]  drdata_o;
   wire         flag_update_o;
   wire  [7:0]  eng_rdata_o;
   int          cmp_count = 0;
   int          miscompares = 0;
   int          cyc = 0;
   logic [3:0]  pulses;
   // {byte address, word}
   logic [23:0] prog [24] = '{24'h000102, 24'h02EF10, 24'h04F000,
      24'h205134, 24'h225134, 24'h245134, 24'h265070, 24'h285010,
      24'h2A50E0, 24'h2C50E0, 24'h2E0105, 24'h305177, 24'h325177,
      24'h34F123, 24'h36C234, 24'h38F010, 24'h3A5010, 24'h3CD002,
      24'h42EC00, 24'h44F000, 24'h46EE15, 24'h48F0AB, 24'h4AEC20,
      24'h4CF000};

   cma_core_addr u_dut (.clk_i, .rst_i, .step_i, .skip_i, .prog_lo_i,
      .prog_hi_i, .dwr_i, .dwdata_i, .usb_en_i, .eng_addr_i, .eng_we_i,
      .eng_wdata_i, .pc_o, .busy_o, .nop_o, .call_o, .ret_addr_o,
      .fsr_load_o, .fsr_sel_o, .fsr_value_o, .bank_pointer_o, .daddr_o,
      .drdata_o, .flag_update_o, .eng_rdata_o);
   cma_fetch_model u_rom (.pc_i(pc_o), .prog_lo_o(prog_lo_i),
      .prog_hi_o(prog_hi_i));

   always #50 clk_i = ~clk_i;

   // ---------------------------------
   // tasks
   // ---------------------------------
   task automatic chk(input string nm, input logic [20:0] e,
                      input logic [20:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one word; pulses caught in the cycle after the taking edge
   task automatic st(input logic sk, input logic [20:0] epc);
      step_i = 1'b1;
      skip_i = sk;
      @(negedge clk_i);
      step_i = 1'b0;
      skip_i = 1'b0;
      pulses = {busy_o, nop_o, call_o, fsr_load_o};
      @(negedge clk_i);
      chk("pc", epc, pc_o);
   endtask

   task automatic wr(input logic [7:0] d);
      dwr_i = 1'b1;
      dwdata_i = d;
      @(negedge clk_i);
      dwr_i = 1'b0;
   endtask

   task automatic eng(input logic en, input logic [7:0] d);
      usb_en_i = en;
      eng_we_i = 1'b1;
      eng_wdata_i = d;
      @(negedge clk_i);
      eng_we_i = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard well above the ~73 cycles of the program
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         end_sim();
      end
   end

   // ---------------------------------
   // sequence
   // ---------------------------------
   initial begin
      {rst_i, step_i, skip_i, dwr_i, usb_en_i, eng_we_i} = 6'h20;
      {dwdata_i, eng_wdata_i, eng_addr_i} = 24'h000034;
      foreach (prog[i]) u_rom.put(prog[i][23:16], prog[i][15:0]);
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      chk("bank", 21'h0, 21'(bank_pointer_o));
      st(0, 21'h02);
      chk("bank", 21'h2, 21'(bank_pointer_o));
      st(0, 21'h04);
      st(0, 21'h20);
      st(0, 21'h22);
      chk("daddr", 21'h234, 21'(daddr_o));
      wr(8'hA5);
      st(0, 21'h24);
      chk("rdata", 21'hA5, 21'(drdata_o));
      eng(1'b0, 8'h3C);
      chk("eng", 21'hA5, 21'(eng_rdata_o));
      eng(1'b1, 8'h3C);
      st(0, 21'h26);
      chk("rdata", 21'h3C, 21'(drdata_o));
      st(0, 21'h28);
      chk("daddr", 21'hF70, 21'(daddr_o));
      st(0, 21'h2A);
      chk("daddr", 21'h010, 21'(daddr_o));
      st(0, 21'h2C);
      chk("rdata", 21'h02, 21'(drdata_o));
      wr(8'hFF);
      st(0, 21'h2E);
      chk("rdata", 21'h0F, 21'(drdata_o));
      st(0, 21'h30);
      st(0, 21'h32);
      chk("daddr", 21'h577, 21'(daddr_o));
      wr(8'h77);
      st(0, 21'h34);
      chk("rdata", 21'h00, 21'(drdata_o));
      chk("flag", 21'h1, 21'(flag_update_o));
      st(0, 21'h36);
      chk("pulses", 21'h4, 21'(pulses));
      st(0, 21'h38);
      st(0, 21'h3A);
      chk("pulses", 21'h8, 21'(pulses));
      st(0, 21'h3C);
      chk("rdata", 21'h3C, 21'(drdata_o));
      st(0, 21'h42);
      st(1, 21'h44);
      chk("pulses", 21'h4, 21'(pulses));
      st(0, 21'h46);
      chk("pulses", 21'h4, 21'(pulses));
      st(0, 21'h48);
      st(0, 21'h4A);
      chk("pulses", 21'h1, 21'(pulses));
      chk("fsr", 21'h15AB, 21'({fsr_sel_o, fsr_value_o}));
      st(0, 21'h4C);
      st(0, 21'h40);
      chk("pulses", 21'h2, 21'(pulses));
      chk("ret", 21'h4E, ret_addr_o);
      end_sim();
   end
endmodule

bind cma_core_addr cma_core_addr_monitor u_mon (.clk_i, .rst_i, .step_i,
   .skip_i, .prog_lo_i, .prog_hi_i, .dwr_i, .pc_o, .busy_o, .nop_o,
   .bank_pointer_o, .daddr_o, .flag_update_o);

`default_nettype wire
